// ---- logic/flash_port_cfg.svh ----
// Constants for the embedded flash user port: register map, fields, timings.
// Assumes inclusion by the flash port module only.
`ifndef FLASH_PORT_CFG_SVH
`define FLASH_PORT_CFG_SVH

// ------------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_CMD         8'h0c
`define REG_STATUS      8'h10
`define REG_RDATA       8'h14

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define CTRL_SIZE_LO    0
`define CTRL_EXTRA      2
`define CTRL_SPARE      3
`define CTRL_GUARD      4
`define CTRL_DIRTYG     5
`define CTRL_PIPE       6
`define CTRL_CLAIM      7
`define CTRL_SEQ        8
`define CTRL_RESET      9'h000

// ------------------------------------------------------------------
// Command register bits (write one to start)
// ------------------------------------------------------------------
`define CMD_READ        0
`define CMD_INFO        1
`define CMD_COMMIT      2
`define CMD_REWRITE     3
`define CMD_ZERO        4
`define CMD_DROP        5
`define CMD_WBUF        6

// ------------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------------
`define STAT_BUSY       0
`define STAT_DIRTY      1
`define STAT_REFUSED    2
`define STAT_PROT_ERR   3

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define READ_NS         20
`define PROG_NS         100
`define CLK_NS          5
`define READ_CYC        ((`READ_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_CYC        ((`PROG_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- logic/flash_port_pkg.sv ----
// Types for the embedded flash user port.
// Assumes the cfg header carries the numbers.
package flash_port_pkg;

    // ------------------------------------------------------------------
    // Sequencer states and operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_PROG,
        ST_DONE
    } seq_state_e;

    typedef enum logic [2:0] {
        OP_READ,
        OP_NEXT,
        OP_INFO,
        OP_COMMIT,
        OP_REWRITE,
        OP_ZERO
    } op_kind_e;

    // Request as latched at acceptance
    typedef struct packed {
        op_kind_e    kind;
        logic [17:0] offset;
        logic [1:0]  size;
        logic        extra;
        logic        spare;
        logic        guard;
    } op_req_s;

endpackage : flash_port_pkg

// ---- logic/flash_port.sv ----
// Embedded flash user port sequencer with page buffer and AXI4-Lite registers.
// Assumes an AXI4-Lite master with one write and one read outstanding at most.
`timescale 1ns/100ps
`include "flash_port_cfg.svh"

module flash_port
    import flash_port_pkg::*;
#(
    parameter int PAGE_BYTES = 128,
    parameter int PAGES      = 16,
    parameter int ADDR_W     = 18
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Status to the outside
    output logic             busy,
    output logic             fabric_claim
);

    localparam int PIDX_W = $clog2(PAGES);
    localparam int BIDX_W = $clog2(PAGE_BYTES);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (ADDR_W != 18 || PAGE_BYTES < 4 || PAGE_BYTES % 4 != 0 ||
        PAGES < 2 || PAGES * PAGE_BYTES > (1 << ADDR_W)) begin : g_bad_geometry
        $error("flash_port: unsupported geometry");
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [8:0]        ctrl_ff;
    logic [17:0]       addr_ff;
    logic [31:0]       wdata_ff;
    logic [31:0]       rdata_ff;
    logic [31:0]       rstage_ff;
    logic              dirty_ff;
    logic              refused_ff;
    logic              prot_err_ff;
    logic [PIDX_W-1:0] buf_page_ff;
    seq_state_e        state_ff;
    op_req_s           op_ff;
    logic [7:0]        cnt_ff;
    logic              pipe_wait_ff;

    // Array: main bytes, one aux word and protect bit per page, one spare page
    logic [7:0]  mem_ff   [PAGES][PAGE_BYTES];
    logic [7:0]  spare_ff [PAGE_BYTES];
    logic [31:0] aux_ff   [PAGES];
    logic [PAGES-1:0] prot_ff;
    logic [7:0]  pbuf_ff  [PAGE_BYTES];

    // ------------------------------------------------------------------
    // AXI write path: take address and data in either order
    // ------------------------------------------------------------------
    logic       aw_held_ff;
    logic       w_held_ff;
    logic [7:0] aw_ff;
    logic [31:0] w_ff;
    logic [3:0] ws_ff;
    logic       wr_go;

    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
    assign wr_go         = aw_held_ff && w_held_ff;

    // Channel capture, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            aw_ff        <= 8'h00;
            w_ff         <= 32'h0000_0000;
            ws_ff        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_ff      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                w_ff      <= s_axi_wdata;
                ws_ff     <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_ff == `REG_CTRL || aw_ff == `REG_ADDR ||
                                 aw_ff == `REG_WDATA || aw_ff == `REG_CMD) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte-lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : merge

    // ------------------------------------------------------------------
    // Command decode: one operation accepted per cycle, none unless the sequencer is in ST_IDLE; drop acts in any state
    // ------------------------------------------------------------------
    logic [31:0] cmd_bits;
    logic        cmd_wr;
    logic        same_page;
    logic        start_ok;
    logic        want_op;
    op_kind_e    nxt_kind;

    assign cmd_wr    = wr_go && aw_ff == `REG_CMD;
    assign cmd_bits  = cmd_wr ? (w_ff & {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}},
                                          {8{ws_ff[0]}}}) : 32'h0000_0000;
    assign same_page = addr_ff[BIDX_W +: PIDX_W] == buf_page_ff;
    assign want_op   = cmd_bits[`CMD_READ] | cmd_bits[`CMD_COMMIT] |
                       cmd_bits[`CMD_REWRITE] | cmd_bits[`CMD_ZERO];
    // Dirty guard refuses other-page access until committed or dropped
    assign start_ok  = want_op && state_ff == ST_IDLE && !(ctrl_ff[`CTRL_DIRTYG] && dirty_ff &&
                       !same_page && !cmd_bits[`CMD_COMMIT]);

    // Priority: read variants first, then commit, rewrite, zero fill
    always_comb begin
        if (cmd_bits[`CMD_READ] && cmd_bits[`CMD_INFO])
            nxt_kind = OP_INFO;
        else if (cmd_bits[`CMD_READ] && ctrl_ff[`CTRL_SEQ])
            nxt_kind = OP_NEXT;
        else if (cmd_bits[`CMD_READ])
            nxt_kind = OP_READ;
        else if (cmd_bits[`CMD_COMMIT])
            nxt_kind = OP_COMMIT;
        else if (cmd_bits[`CMD_REWRITE])
            nxt_kind = OP_REWRITE;
        else
            nxt_kind = OP_ZERO;
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff  <= `CTRL_RESET;
            addr_ff  <= 18'h00000;
            wdata_ff <= 32'h0000_0000;
        end else if (wr_go) begin
            if (aw_ff == `REG_CTRL)
                ctrl_ff <= 9'(merge({23'h0, ctrl_ff}, w_ff, ws_ff));
            else if (aw_ff == `REG_ADDR)
                addr_ff <= 18'(merge({14'h0, addr_ff}, w_ff, ws_ff));
            else if (aw_ff == `REG_WDATA)
                wdata_ff <= merge(wdata_ff, w_ff, ws_ff);
        end else if (state_ff == ST_DONE && op_ff.kind == OP_NEXT) begin
            // Read-next advances the offset by the transfer width
            addr_ff <= addr_ff + (op_ff.size[1] ? 18'h4 : op_ff.size[0] ? 18'h2 : 18'h1);
        end
    end

    assign fabric_claim = ctrl_ff[`CTRL_CLAIM];

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            op_ff    <= '0;
            cnt_ff   <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start_ok) begin
                        op_ff <= '{kind: nxt_kind, offset: addr_ff,
                                   size: ctrl_ff[`CTRL_SIZE_LO +: 2],
                                   extra: ctrl_ff[`CTRL_EXTRA], spare: ctrl_ff[`CTRL_SPARE],
                                   guard: ctrl_ff[`CTRL_GUARD]};
                        cnt_ff   <= 8'(cmd_bits[`CMD_READ] ? `READ_CYC : `PROG_CYC);
                        state_ff <= cmd_bits[`CMD_READ] ? ST_READ : ST_PROG;
                    end
                end
                ST_READ, ST_PROG: begin
                    cnt_ff <= cnt_ff - 8'h1;
                    if (cnt_ff == 8'h1)
                        state_ff <= ST_DONE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Busy covers the operation and the optional output stage
    assign busy = state_ff != ST_IDLE || pipe_wait_ff;

    // ------------------------------------------------------------------
    // Array and page buffer
    // ------------------------------------------------------------------
    logic [PIDX_W-1:0] op_page;
    logic [BIDX_W-1:0] op_byte;
    logic              prog_en;
    logic              zero;
    assign op_page = op_ff.offset[BIDX_W +: PIDX_W];
    assign op_byte = op_ff.offset[BIDX_W-1:0];
    assign zero    = op_ff.kind == OP_ZERO;
    // Rewrite only lands on an unprotected page
    assign prog_en = state_ff == ST_DONE &&
                     (op_ff.kind == OP_COMMIT || zero ||
                      (op_ff.kind == OP_REWRITE && !prot_ff[op_page]));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prot_ff <= '0;
        end else if (prog_en) begin
            if (op_ff.guard)
                prot_ff[op_page] <= 1'b1;
            if (op_ff.extra)
                aux_ff[op_page] <= zero ? 32'h0 : {pbuf_ff[3], pbuf_ff[2],
                                                    pbuf_ff[1], pbuf_ff[0]};
        end
    end

    // Per-byte program of main or spare page; zero fill overrides the buffer
    for (genvar b = 0; b < PAGE_BYTES; b++) begin : g_byte
        always_ff @(posedge aclk) begin
            if (prog_en && !op_ff.extra && op_ff.spare)
                spare_ff[b] <= zero ? 8'h00 : pbuf_ff[b];
        end
        // One process per cell keeps every array element single-driven
        for (genvar p = 0; p < PAGES; p++) begin : g_page
            always_ff @(posedge aclk) begin
                if (prog_en && !op_ff.extra && !op_ff.spare && op_page == PIDX_W'(p))
                    mem_ff[p][b] <= zero ? 8'h00 : pbuf_ff[b];
            end
        end
        // Buffer fill from write data at the current offset, sized lanes
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pbuf_ff[b] <= 8'h00;
            end else if (cmd_bits[`CMD_WBUF] && state_ff == ST_IDLE) begin
                if (BIDX_W'(b) == addr_ff[BIDX_W-1:0] ||
                    (ctrl_ff[`CTRL_SIZE_LO +: 2] != 2'b00 && BIDX_W'(b) == addr_ff[BIDX_W-1:0] + 1) ||
                    (ctrl_ff[`CTRL_SIZE_LO + 1] && BIDX_W'(b) >= addr_ff[BIDX_W-1:0] + 2 &&
                     BIDX_W'(b) <= addr_ff[BIDX_W-1:0] + 3))
                    pbuf_ff[b] <= wdata_ff[8*(BIDX_W'(b) - addr_ff[BIDX_W-1:0]) +: 8];
            end
        end
    end

    // Dirty tracking: set wins over drop or commit in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dirty_ff    <= 1'b0;
            buf_page_ff <= '0;
        end else if (cmd_bits[`CMD_WBUF] && state_ff == ST_IDLE) begin
            dirty_ff    <= 1'b1;
            buf_page_ff <= addr_ff[BIDX_W +: PIDX_W];
        end else if (cmd_bits[`CMD_DROP] || prog_en && op_ff.kind != OP_ZERO) begin
            dirty_ff <= 1'b0;
        end
    end

    // Sticky refusal and protection error flags, cleared by a control write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refused_ff  <= 1'b0;
            prot_err_ff <= 1'b0;
        end else begin
            if (want_op && !start_ok)
                refused_ff <= 1'b1;
            else if (wr_go && aw_ff == `REG_CTRL)
                refused_ff <= 1'b0;
            if (state_ff == ST_DONE && op_ff.kind == OP_REWRITE && prot_ff[op_page])
                prot_err_ff <= 1'b1;
            else if (wr_go && aw_ff == `REG_CTRL)
                prot_err_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data path with optional output stage
    // ------------------------------------------------------------------
    logic [31:0] raw;
    always_comb begin
        raw = 32'h0;
        if (op_ff.kind == OP_INFO)
            raw = {29'h0, dirty_ff && buf_page_ff == op_page, prot_ff[op_page], 1'b1};
        else if (op_ff.extra)
            raw = aux_ff[op_page];
        else
            for (int i = 0; i < 4; i++)
                raw[i*8 +: 8] = op_ff.spare ? spare_ff[BIDX_W'(op_byte + i)] :
                                              mem_ff[op_page][BIDX_W'(op_byte + i)];
        if (op_ff.size == 2'b00)
            raw[31:8] = 24'h0;
        else if (op_ff.size == 2'b01)
            raw[31:16] = 16'h0;
    end

    logic rd_done;
    assign rd_done = state_ff == ST_DONE && (op_ff.kind == OP_READ ||
                     op_ff.kind == OP_NEXT || op_ff.kind == OP_INFO);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rstage_ff    <= 32'h0;
            rdata_ff     <= 32'h0;
            pipe_wait_ff <= 1'b0;
        end else begin
            pipe_wait_ff <= rd_done && ctrl_ff[`CTRL_PIPE];
            if (rd_done)
                rstage_ff <= raw;
            if (rd_done && !ctrl_ff[`CTRL_PIPE])
                rdata_ff <= raw;
            else if (pipe_wait_ff)
                rdata_ff <= rstage_ff;
        end
    end

    // ------------------------------------------------------------------
    // AXI read path
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            if (s_axi_araddr == `REG_CTRL)
                s_axi_rdata <= {23'h0, ctrl_ff};
            else if (s_axi_araddr == `REG_ADDR)
                s_axi_rdata <= {14'h0, addr_ff};
            else if (s_axi_araddr == `REG_WDATA)
                s_axi_rdata <= wdata_ff;
            else if (s_axi_araddr == `REG_CMD)
                s_axi_rdata <= 32'h0;
            else if (s_axi_araddr == `REG_STATUS)
                s_axi_rdata <= {28'h0, prot_err_ff, refused_ff, dirty_ff, busy};
            else if (s_axi_araddr == `REG_RDATA)
                s_axi_rdata <= rdata_ff;
            else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_start;
        state_ff == ST_IDLE && start_ok;
    endsequence

    a_busy_after_start: assert property (@(posedge aclk) disable iff (!aresetn)
        s_start |=> busy) else $error("busy not raised");
    a_read_len: assert property (@(posedge aclk) disable iff (!aresetn)
        s_start ##0 cmd_bits[`CMD_READ] |-> ##(`READ_CYC + 1) state_ff == ST_DONE)
        else $error("read length wrong");
    a_prog_len: assert property (@(posedge aclk) disable iff (!aresetn)
        s_start ##0 !cmd_bits[`CMD_READ] |-> ##(`PROG_CYC + 1) state_ff == ST_DONE)
        else $error("program length wrong");
    a_dirty_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
        want_op && ctrl_ff[`CTRL_DIRTYG] && dirty_ff && !same_page && !cmd_bits[`CMD_COMMIT]
        |-> !start_ok) else $error("dirty guard bypassed");
    a_rewrite_prot: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == ST_DONE && op_ff.kind == OP_REWRITE && prot_ff[op_page] |-> !prog_en)
        else $error("protected page rewritten");
    a_guard_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_en && op_ff.guard |=> prot_ff[$past(op_page)]) else $error("guard bit lost");
    a_drop_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_bits[`CMD_DROP] && !cmd_bits[`CMD_WBUF] |=> !dirty_ff)
        else $error("drop ignored");
    a_pipe_extra: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_done && ctrl_ff[`CTRL_PIPE] |=> busy ##1 !busy) else $error("pipe stage wrong");
    a_data_at_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(busy) && $past(op_ff.kind == OP_READ) |-> rdata_ff == rstage_ff)
        else $error("read data late");
    a_one_op: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff != ST_IDLE |=> $stable(op_ff)) else $error("second op accepted");

endmodule : flash_port

// ---- bench/fabric_user_model.sv ----
// AXI4-Lite master standing in for the fabric user logic.
// Assumes the flash port slave shares aclk; one access at a time.
`timescale 1ns/100ps

module fabric_user_model (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // Idle values; full strobes so every byte lane lands
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end

    // Write: address and data together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    // Read: address held until taken, data taken at rvalid edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : fabric_user_model

// ---- bench/embedded_flash_user_port_tb_top.sv ----
// Self-checking bench for the flash user port over AXI4-Lite.
// Assumes the fabric model drives the bus; bench owns clock and reset.
`timescale 1ns/100ps

module embedded_flash_user_port_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        busy, fabric_claim;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #2.5 aclk = ~aclk;

    flash_port flash_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy, .fabric_claim);
    fabric_user_model fabric_user_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Short forms: register write, register read and compare
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        fabric_user_model_i.wr(a, d, resp);
    endtask : w

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        fabric_user_model_i.rd(a, got, resp);
        chk(got, e);
    endtask : rc

    task automatic summarize;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Hang guard, far above the few hundred cycles the scenarios need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    // Start a flash command and wait, bounded, for busy to fall
    task automatic run_cmd(input logic [31:0] c);
        int n;
        n = 0;
        fabric_user_model_i.wr(8'h0c, c, resp);
        chk(busy, 1'b1);
        while (busy !== 1'b0 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        chk(busy, 1'b0);
    endtask : run_cmd

    task automatic t_claim;
        chk({busy, fabric_claim}, 2'b00);
        fabric_user_model_i.wr(8'h00, 32'h80, resp);
        chk(fabric_claim, 1'b1);
        fabric_user_model_i.wr(8'h00, 32'h02, resp);
        chk(fabric_claim, 1'b0);
    endtask : t_claim

    // Fill buffer, commit page 1, read back at every transfer size
    task automatic t_commit_read;
        logic [31:0] e [3] = '{32'h78, 32'h5678, 32'h12345678};
        fabric_user_model_i.wr(8'h04, 32'h80, resp);
        fabric_user_model_i.wr(8'h08, 32'h12345678, resp);
        fabric_user_model_i.wr(8'h0c, 32'h40, resp);
        run_cmd(32'h04);
        for (int i = 0; i < 3; i++) begin
            fabric_user_model_i.wr(8'h00, i, resp);
            run_cmd(32'h01);
            fabric_user_model_i.rd(8'h14, got, resp);
            chk(got, e[i]);
        end
    endtask : t_commit_read

    task automatic t_zero_and_errors;
        run_cmd(32'h10);
        fabric_user_model_i.rd(8'h14, got, resp);
        chk(got, 32'h12345678);
        run_cmd(32'h01);
        fabric_user_model_i.rd(8'h14, got, resp);
        chk(got, 32'h0);
        fabric_user_model_i.rd(8'h3c, got, resp);
        chk(resp, 2'h2);
        fabric_user_model_i.wr(8'h10, 32'h0, resp);
        chk(resp, 2'h2);
    endtask : t_zero_and_errors

    // Info, dirty guard, drop, read-next, pipe, extra area, write guard, spare
    task automatic t_modes;
        w(8'h00, 32'h160);
        w(8'h08, 32'ha5);
        w(8'h0c, 32'h40);
        run_cmd(32'h03);
        rc(8'h14, 32'h5);
        w(8'h04, 32'h100);
        w(8'h0c, 32'h01);
        rc(8'h10, 32'h6);
        w(8'h0c, 32'h20);
        rc(8'h10, 32'h4);
        w(8'h04, 32'h80);
        run_cmd(32'h01);
        rc(8'h04, 32'h81);
        rc(8'h14, 32'h0);
        w(8'h00, 32'h16);
        w(8'h04, 32'h80);
        w(8'h08, 32'hcafe0123);
        w(8'h0c, 32'h40);
        run_cmd(32'h04);
        run_cmd(32'h01);
        rc(8'h14, 32'hcafe0123);
        run_cmd(32'h08);
        rc(8'h10, 32'h8);
        w(8'h00, 32'h0a);
        run_cmd(32'h04);
        run_cmd(32'h01);
        rc(8'h14, 32'hcafe0123);
    endtask : t_modes

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_claim();
        t_commit_read();
        t_zero_and_errors();
        t_modes();
        summarize();
    end
endmodule : embedded_flash_user_port_tb_top
